// ### hdl/sps_params.svh
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH

// Register addresses on the serial register port
`define SPS_ADDR_SOFT_RESET    9'h00A
`define SPS_ADDR_CLOCK_DIST    9'h020
`define SPS_ADDR_COLUMN_MUX    9'h028
`define SPS_ADDR_IMAGE_CORE    9'h029
`define SPS_ADDR_FRONT_END     9'h030
`define SPS_ADDR_BIAS_ENABLE   9'h040
`define SPS_ADDR_PUMP_BIAS     9'h041
`define SPS_ADDR_FE_BIAS       9'h042
`define SPS_ADDR_MUX_BIAS      9'h043
`define SPS_ADDR_SER_BIAS      9'h044
`define SPS_ADDR_RESERVED_A    9'h046
`define SPS_ADDR_PUMP_ENABLE   9'h048
`define SPS_ADDR_RESERVED_B    9'h051
`define SPS_ADDR_OUTPUT_DRV    9'h070
`define SPS_ADDR_BLACK_LEVEL   9'h080
`define SPS_ADDR_PIXEL_WIDTH   9'h081
`define SPS_ADDR_EXPOSURE_A    9'h0B0
`define SPS_ADDR_EXPOSURE_B    9'h0B4
`define SPS_ADDR_EXPOSURE_C    9'h0B5
`define SPS_ADDR_SEQ_MODE      9'h0C0
`define SPS_ADDR_SEQ_CFG_A     9'h0DA
`define SPS_ADDR_SEQ_CFG_B     9'h0E0
`define SPS_ADDR_SEQ_CFG_D     9'h1BF
`define SPS_ADDR_SEQ_CFG_E     9'h1C0
`define SPS_ADDR_SEQ_CFG_C     9'h1C8
`define SPS_ADDR_STATUS        9'h1FF

// Prescribed values of the reserved upload
`define SPS_VAL_IMAGE_CORE     16'h085A
`define SPS_VAL_PUMP_BIAS      16'h288B
`define SPS_VAL_FE_BIAS        16'h53C6
`define SPS_VAL_MUX_BIAS       16'h0344
`define SPS_VAL_SER_BIAS       16'h0085
`define SPS_VAL_RESERVED_A     16'h4888
`define SPS_VAL_RESERVED_B     16'h86A1
`define SPS_VAL_BLACK_LEVEL    16'h460F
`define SPS_VAL_EXPOSURE_A     16'h00F5
`define SPS_VAL_EXPOSURE_B     16'h00FD
`define SPS_VAL_EXPOSURE_C     16'h0144
`define SPS_VAL_SEQ_CFG_A      16'h160B
`define SPS_VAL_SEQ_CFG_B      16'h3E13
`define SPS_VAL_SEQ_CFG_C      16'h0386
`define SPS_VAL_SEQ_CFG_D      16'h0BF1
`define SPS_VAL_SEQ_CFG_E      16'h0BC3

// Field positions
`define SPS_BIT_PIXEL_8        13
`define SPS_BIT_SEQ_ENABLE     0
`define SPS_BIT_ANALOG_CLK     0

// Reset values
`define SPS_RST_SOFT_RESET     16'h0999
`define SPS_RST_ZERO16         16'h0000

// Frame layout on the serial port; sequencer frame length in core cycles
`define SPS_FRAME_WR_BIT       5'h09
`define SPS_FRAME_LAST_BIT     5'h19
`define SPS_FRAME_DONE         5'h1A
`define SPS_FRAME_CYCLES       1024

`endif

// ### hdl/sps_pkg.sv
package sps_pkg;
  typedef enum logic [1:0] {st_standby, st_idle, st_running} sps_state_t;
  typedef logic [8:0]  sps_addr_t;
  typedef logic [15:0] sps_word_t;
endpackage : sps_pkg

// ### hdl/sps_regmem.sv
`timescale 1ns/10ps
module sps_regmem
  import sps_pkg::*;
#(
  parameter int AW = 9,
  parameter int DW = 16
)
(
  input  wire logic          clk,      // Link clock
  input  wire logic          we,       // Write strobe
  input  wire logic [AW-1:0] wr_addr,  // Write address
  input  wire logic [DW-1:0] wr_data,  // Write data
  input  wire logic [AW-1:0] rd_addr,  // Read address
  output logic      [DW-1:0] rd_data   // Registered read data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rd_q;

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_q <= mem[rd_addr];
  end

  assign rd_data = rd_q;
endmodule : sps_regmem

// ### hdl/sps_sequencer.sv
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_sequencer
  import sps_pkg::*;
#(
  parameter int FRAME_CYCLES = `SPS_FRAME_CYCLES
)
(
  input  wire logic       ref_clk,           // Core clock, 50 MHz
  input  wire logic       rst,               // Reset, active high; synchronous except for the write toggle, which it clears asynchronously
  input  wire logic       spi_sclk,          // Serial port clock
  input  wire logic       spi_cs_n,          // Serial port select, active low
  input  wire logic       spi_sdi,           // Serial data in
  output logic            spi_sdo,           // Serial data out
  output logic            spi_sdo_oe,        // Serial data out enable
  input  wire logic [9:0] sample_in,         // Raw 10-bit sample
  input  wire logic       sample_valid,      // Raw sample strobe
  output logic      [9:0] sample_out,        // Formatted sample
  output logic            sample_out_valid,  // Formatted sample strobe
  output logic            soft_reset_active, // Internal blocks held in soft reset
  output logic            blocks_ready,      // All blocks except the serial transmitters powered up
  output logic      [2:0] serial_tx_en,      // Serial transmitter enables
  output logic            seq_running,       // Frame sequencer running
  output logic     [14:0] seq_mode,          // Mode latched at sequencer start
  output logic            frame_start,       // One pulse per frame
  output logic            cfg_error          // Wrong reserved value seen
);
  // Link side: frame shifter, register memory, write hand-off
  logic [4:0]  bit_cnt, next_bit_cnt;
  sps_word_t   in_sh, next_in_sh;
  sps_word_t   out_sh, next_out_sh;
  sps_addr_t   frm_addr, next_frm_addr;
  logic        frm_wr, next_frm_wr;
  sps_addr_t   hold_addr, next_hold_addr;
  sps_word_t   hold_data, next_hold_data;
  logic        wr_tgl, next_wr_tgl;
  logic        mem_we;
  sps_word_t   mem_rdata;
  sps_word_t   wr_word;
  logic [1:0]  st_s1, st_s2, st_s3, st_val, next_st_val;

  assign wr_word = {in_sh[14:0], spi_sdi};

  sps_regmem #(.AW(9), .DW(16)) u_regmem (
    .clk     (spi_sclk),
    .we      (mem_we),
    .wr_addr (frm_addr),
    .wr_data (wr_word),
    .rd_addr ({in_sh[7:0], spi_sdi}),
    .rd_data (mem_rdata)
  );

  always_comb
  begin
    next_bit_cnt   = bit_cnt;
    next_in_sh     = wr_word;
    next_out_sh    = {out_sh[14:0], 1'b0};
    next_frm_addr  = frm_addr;
    next_frm_wr    = frm_wr;
    next_hold_addr = hold_addr;
    next_hold_data = hold_data;
    next_wr_tgl    = wr_tgl;
    mem_we         = 1'b0;
    if (bit_cnt != `SPS_FRAME_DONE)
    begin
      next_bit_cnt = bit_cnt + 5'h01;
    end
    if (bit_cnt == 5'h08)
    begin
      next_frm_addr = {in_sh[7:0], spi_sdi};
    end
    if (bit_cnt == `SPS_FRAME_WR_BIT)
    begin
      next_frm_wr = spi_sdi;
      next_out_sh = (frm_addr == `SPS_ADDR_STATUS) ? {14'h0000, st_val} : mem_rdata;
    end
    if (bit_cnt == `SPS_FRAME_LAST_BIT && frm_wr)
    begin
      mem_we         = 1'b1;
      next_hold_addr = frm_addr;
      next_hold_data = wr_word;
      next_wr_tgl    = ~wr_tgl;
    end
    next_st_val = (st_s2 & ~(st_s2 ^ st_s3)) | (st_val & (st_s2 ^ st_s3));
  end

  // Select going high clears the bit position, since the link clock stops between frames
  always_ff @(posedge spi_sclk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      bit_cnt <= 5'h00;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // Toggle must not move at reset release, so it clears asynchronously
  always_ff @(posedge spi_sclk or posedge rst)
  begin
    if (rst)
    begin
      wr_tgl <= 1'b0;
    end
    else
    begin
      wr_tgl <= next_wr_tgl;
    end
  end

  always_ff @(posedge spi_sclk)
  begin
    in_sh     <= next_in_sh;
    out_sh    <= next_out_sh;
    frm_addr  <= next_frm_addr;
    frm_wr    <= next_frm_wr;
    hold_addr <= next_hold_addr;
    hold_data <= next_hold_data;
    st_s1     <= {seq_running, blocks_ready};
    st_s2     <= st_s1;
    st_s3     <= st_s2;
    st_val    <= next_st_val;
  end

  assign spi_sdo    = out_sh[15];
  assign spi_sdo_oe = ~spi_cs_n & ~frm_wr & (bit_cnt > `SPS_FRAME_WR_BIT) & (bit_cnt != `SPS_FRAME_DONE);

  // Core side: write capture, control registers, power state
  function automatic logic [16:0] sps_expected(input sps_addr_t a);
    case (a)
      `SPS_ADDR_IMAGE_CORE:  sps_expected = {1'b1, `SPS_VAL_IMAGE_CORE};
      `SPS_ADDR_PUMP_BIAS:   sps_expected = {1'b1, `SPS_VAL_PUMP_BIAS};
      `SPS_ADDR_FE_BIAS:     sps_expected = {1'b1, `SPS_VAL_FE_BIAS};
      `SPS_ADDR_MUX_BIAS:    sps_expected = {1'b1, `SPS_VAL_MUX_BIAS};
      `SPS_ADDR_SER_BIAS:    sps_expected = {1'b1, `SPS_VAL_SER_BIAS};
      `SPS_ADDR_RESERVED_A:  sps_expected = {1'b1, `SPS_VAL_RESERVED_A};
      `SPS_ADDR_RESERVED_B:  sps_expected = {1'b1, `SPS_VAL_RESERVED_B};
      `SPS_ADDR_BLACK_LEVEL: sps_expected = {1'b1, `SPS_VAL_BLACK_LEVEL};
      `SPS_ADDR_EXPOSURE_A:  sps_expected = {1'b1, `SPS_VAL_EXPOSURE_A};
      `SPS_ADDR_EXPOSURE_B:  sps_expected = {1'b1, `SPS_VAL_EXPOSURE_B};
      `SPS_ADDR_EXPOSURE_C:  sps_expected = {1'b1, `SPS_VAL_EXPOSURE_C};
      `SPS_ADDR_SEQ_CFG_A:   sps_expected = {1'b1, `SPS_VAL_SEQ_CFG_A};
      `SPS_ADDR_SEQ_CFG_B:   sps_expected = {1'b1, `SPS_VAL_SEQ_CFG_B};
      `SPS_ADDR_SEQ_CFG_C:   sps_expected = {1'b1, `SPS_VAL_SEQ_CFG_C};
      `SPS_ADDR_SEQ_CFG_D:   sps_expected = {1'b1, `SPS_VAL_SEQ_CFG_D};
      `SPS_ADDR_SEQ_CFG_E:   sps_expected = {1'b1, `SPS_VAL_SEQ_CFG_E};
      default:               sps_expected = 17'h0_0000;
    endcase
  endfunction : sps_expected

  logic        w_s1, w_s2, w_s3, wr_seen, next_wr_seen, wr_event;
  logic [16:0] exp_val;
  sps_word_t   soft_rst_reg, next_soft_rst_reg;
  sps_word_t   seq_ctrl, next_seq_ctrl;
  logic        clk_analog, next_clk_analog;
  logic        bias_en, next_bias_en;
  logic        pump_en, next_pump_en;
  logic        mux_en, next_mux_en;
  logic        afe_en, next_afe_en;
  logic        pix8, next_pix8;
  logic [2:0]  next_serial_tx_en;
  logic        next_cfg_error;

  assign wr_event = (w_s2 == w_s3) && (w_s3 != wr_seen);
  assign exp_val  = sps_expected(hold_addr);

  always_comb
  begin
    next_wr_seen      = wr_event ? w_s3 : wr_seen;
    next_soft_rst_reg = soft_rst_reg;
    next_seq_ctrl     = seq_ctrl;
    next_clk_analog   = clk_analog;
    next_bias_en      = bias_en;
    next_pump_en      = pump_en;
    next_mux_en       = mux_en;
    next_afe_en       = afe_en;
    next_pix8         = pix8;
    next_serial_tx_en = serial_tx_en;
    next_cfg_error    = cfg_error;
    if (wr_event)
    begin
      case (hold_addr)
        `SPS_ADDR_CLOCK_DIST:  next_clk_analog = hold_data[`SPS_BIT_ANALOG_CLK];
        `SPS_ADDR_SOFT_RESET:  next_soft_rst_reg = hold_data;
        `SPS_ADDR_BIAS_ENABLE: next_bias_en = hold_data[0];
        `SPS_ADDR_PUMP_ENABLE: next_pump_en = hold_data[0] & hold_data[1];
        `SPS_ADDR_COLUMN_MUX:  next_mux_en = hold_data[0] & hold_data[1];
        `SPS_ADDR_FRONT_END:   next_afe_en = hold_data[0];
        `SPS_ADDR_OUTPUT_DRV:  next_serial_tx_en = hold_data[2:0];
        `SPS_ADDR_PIXEL_WIDTH: next_pix8 = hold_data[`SPS_BIT_PIXEL_8];
        `SPS_ADDR_SEQ_MODE:    next_seq_ctrl = hold_data;
        default:               next_seq_ctrl = seq_ctrl;
      endcase
      if (exp_val[16] && exp_val[15:0] != hold_data)
      begin
        next_cfg_error = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    w_s1 <= wr_tgl;
    w_s2 <= w_s1;
    w_s3 <= w_s2;
    if (rst)
    begin
      wr_seen      <= 1'b0;
      soft_rst_reg <= `SPS_RST_SOFT_RESET;
      seq_ctrl     <= `SPS_RST_ZERO16;
      clk_analog   <= 1'b0;
      bias_en      <= 1'b0;
      pump_en      <= 1'b0;
      mux_en       <= 1'b0;
      afe_en       <= 1'b0;
      pix8         <= 1'b0;
      serial_tx_en <= 3'h0;
      cfg_error    <= 1'b0;
    end
    else
    begin
      wr_seen      <= next_wr_seen;
      soft_rst_reg <= next_soft_rst_reg;
      seq_ctrl     <= next_seq_ctrl;
      clk_analog   <= next_clk_analog;
      bias_en      <= next_bias_en;
      pump_en      <= next_pump_en;
      mux_en       <= next_mux_en;
      afe_en       <= next_afe_en;
      pix8         <= next_pix8;
      serial_tx_en <= next_serial_tx_en;
      cfg_error    <= next_cfg_error;
    end
  end

  // Ready once every block except the serial transmitters is up
  assign soft_reset_active = (soft_rst_reg != `SPS_RST_ZERO16);
  assign blocks_ready = ~soft_reset_active & clk_analog & bias_en & pump_en & mux_en & afe_en;

  // Acquisition state and frame timing
  sps_state_t  state, next_state;
  logic [15:0] frame_cnt, next_frame_cnt;
  logic [14:0] next_seq_mode;
  logic        seq_en;

  assign seq_en = seq_ctrl[`SPS_BIT_SEQ_ENABLE];

  always_comb
  begin
    next_state     = state;
    next_seq_mode  = seq_mode;
    next_frame_cnt = 16'h0000;
    case (state)
      st_standby:
      begin
        if (blocks_ready)
        begin
          next_state = st_idle;
        end
      end
      st_idle:
      begin
        if (!blocks_ready)
        begin
          next_state = st_standby;
        end
        else if (seq_en)
        begin
          next_state    = st_running;
          next_seq_mode = seq_ctrl[15:1];
        end
      end
      st_running:
      begin
        if (!blocks_ready)
        begin
          next_state = st_standby;
        end
        else if (!seq_en)
        begin
          next_state = st_idle;
        end
        else if (frame_cnt != 16'(FRAME_CYCLES - 1))
        begin
          next_frame_cnt = frame_cnt + 16'h0001;
        end
      end
      default:
      begin
        next_state = st_standby;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state     <= st_standby;
      seq_mode  <= 15'h0000;
      frame_cnt <= 16'h0000;
    end
    else
    begin
      state     <= next_state;
      seq_mode  <= next_seq_mode;
      frame_cnt <= next_frame_cnt;
    end
  end

  assign seq_running = (state == st_running);
  assign frame_start = seq_running && (frame_cnt == 16'h0000);

  logic [9:0] next_sample_out;
  assign next_sample_out = pix8 ? {2'b00, sample_in[9:2]} : sample_in;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sample_out       <= 10'h000;
      sample_out_valid <= 1'b0;
    end
    else
    begin
      sample_out       <= sample_valid ? next_sample_out : sample_out;
      sample_out_valid <= sample_valid;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_idle_armed;
    state == st_idle && seq_en && blocks_ready;
  endsequence

  sequence s_started;
    s_idle_armed ##1 seq_running;
  endsequence

  a_seq_start_ok: assert property (s_idle_armed |=> seq_running)
    else $error("sequencer did not start");
  a_mode_latched: assert property (s_started |-> seq_mode == $past(seq_ctrl[15:1]))
    else $error("mode not latched at start");
  a_seq_stop_ok: assert property (seq_running && !seq_en && blocks_ready |=> state == st_idle)
    else $error("sequencer did not stop to idle");
  a_ready_when_on: assert property (state != st_standby |-> blocks_ready)
    else $error("active state without ready blocks");
  a_pixel_8bit: assert property (sample_valid && pix8 |=> sample_out == {2'b00, $past(sample_in[9:2])})
    else $error("8-bit formatting wrong");
  a_pixel_10bit: assert property (sample_valid && !pix8 |=> sample_out == $past(sample_in))
    else $error("10-bit formatting wrong");
  a_soft_release: assert property (wr_event && hold_addr == `SPS_ADDR_SOFT_RESET && hold_data == 16'h0000
                                   |=> !soft_reset_active)
    else $error("soft reset not released");
  a_tx_enable: assert property (wr_event && hold_addr == `SPS_ADDR_OUTPUT_DRV
                                |=> serial_tx_en == $past(hold_data[2:0]))
    else $error("transmitter enables not updated");
  a_cfg_sticky: assert property (cfg_error |=> cfg_error [*4])
    else $error("configuration error flag dropped");
endmodule : sps_sequencer

// ### tb/sps_host_model.sv
`timescale 1ns/10ps
module sps_host_model
  import sps_pkg::*;
(
  output logic      spi_sclk,   // Link clock, still between frames
  output logic      spi_cs_n,   // Frame select, active low
  output logic      spi_sdi,    // Serial data to device
  input  wire logic spi_sdo,    // Read data from device
  input  wire logic spi_sdo_oe  // Device drives read data
);
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b0;
  end

  // whole frame, one at a time
  task automatic frame(input sps_addr_t addr, input logic wr, input sps_word_t wdata, output sps_word_t rdata);
    logic [25:0] bits;
    bits     = {addr, wr, wdata};
    rdata    = 16'h0000;
    spi_cs_n = 1'b0;
    for (int i = 25; i >= 0; i--)
    begin
      // Read slots carry a toggling pattern, never the write data
      spi_sdi = (!wr && i < 16) ? ~spi_sdi : bits[i];
      #6;
      if (i < 16)
        rdata = {rdata[14:0], spi_sdo_oe ? spi_sdo : 1'bx};
      spi_sclk = 1'b1;
      #6;
      spi_sclk = 1'b0;
    end
    #6;
    spi_cs_n = 1'b1;
    // Released line must not show a stale bit
    spi_sdi = ~spi_sdi;
    #12;
  endtask : frame

  task automatic write_reg(input sps_addr_t addr, input sps_word_t data);
    sps_word_t unused;
    frame(addr, 1'b1, data, unused);
  endtask : write_reg

  task automatic read_reg(input sps_addr_t addr, output sps_word_t data);
    frame(addr, 1'b0, 16'h0000, data);
  endtask : read_reg
endmodule : sps_host_model

// ### tb/test_sensor_power_up_upload_sequencer.sv
`timescale 1ns/10ps
module test_sensor_power_up_upload_sequencer
  import sps_pkg::*;
;
  localparam int FRAME = 8;
  logic        ref_clk, rst, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic [9:0]  sample_in, sample_out;
  logic        sample_valid, sample_out_valid, soft_reset_active, blocks_ready;
  logic [2:0]  serial_tx_en;
  logic        seq_running, frame_start, cfg_error;
  logic [14:0] seq_mode, mode;
  logic [31:0] rng = 32'h0000_FC10;
  int          err_count, n_compared, pulses;
  sps_word_t   rd, val;
  logic [9:0]  prev;

  sps_addr_t res_addr [17] = '{9'h029, 9'h081, 9'h041, 9'h042, 9'h043, 9'h044, 9'h046, 9'h051, 9'h080,
                               9'h0B0, 9'h0B4, 9'h0B5, 9'h0DA, 9'h0E0, 9'h1C8, 9'h1BF, 9'h1C0};
  sps_word_t res_data [17] = '{16'h085A, 16'h0000, 16'h288B, 16'h53C6, 16'h0344, 16'h0085, 16'h4888, 16'h86A1,
                               16'h460F, 16'h00F5, 16'h00FD, 16'h0144, 16'h160B, 16'h3E13, 16'h0386, 16'h0BF1,
                               16'h0BC3};
  sps_addr_t up_addr [7]  = '{9'h020, 9'h00A, 9'h040, 9'h048, 9'h028, 9'h030, 9'h070};
  sps_word_t up_data [7]  = '{16'h0000, 16'h0000, 16'h0001, 16'h0203, 16'h0003, 16'h0001, 16'h0000};
  // Five output modes: clock word, pixel width, output driver word
  sps_word_t clk_word [5] = '{16'h200F, 16'h200B, 16'h2007, 16'h2003, 16'h200F};
  logic      px8 [5]      = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  sps_word_t tx_word [5]  = '{16'h0007, 16'h0007, 16'h0007, 16'h0007, 16'h0000};

  sps_sequencer #(.FRAME_CYCLES(FRAME)) DUT (
    .ref_clk(ref_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .sample_in(sample_in), .sample_valid(sample_valid),
    .sample_out(sample_out), .sample_out_valid(sample_out_valid), .soft_reset_active(soft_reset_active),
    .blocks_ready(blocks_ready), .serial_tx_en(serial_tx_en), .seq_running(seq_running),
    .seq_mode(seq_mode), .frame_start(frame_start), .cfg_error(cfg_error));

  sps_host_model host (
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift

  function automatic logic [9:0] exp_sample(input logic [9:0] s, input logic eight);
    return eight ? {2'b00, s[9:2]} : s;
  endfunction : exp_sample

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : check

  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Write latency is 3..4 core cycles
  task automatic settle;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic do_reset;
    @(posedge ref_clk);
    #1 rst = 1'b1;
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
  endtask : do_reset

  initial
  begin
    rst = 1'b1;
    sample_in = 10'h000;
    sample_valid = 1'b0;
    for (int m = 0; m < 5; m++)
    begin
      do_reset();
      check("soft_reset_active", 16'h0001, soft_reset_active);
      check("blocks_ready", 16'h0000, blocks_ready);
      for (int i = 0; i < 17; i++)
      begin
        val = (i == 1) ? {2'b00, px8[m], 13'h0000} : res_data[i];
        host.write_reg(res_addr[i], val);
      end
      settle();
      check("cfg_error", 16'h0000, cfg_error);
      for (int j = 0; j < 7; j++)
      begin
        val = (j == 0) ? clk_word[m] : (j == 6) ? tx_word[m] : up_data[j];
        host.write_reg(up_addr[j], val);
        settle();
        if (j == 1)
          check("soft_reset_active", 16'h0000, soft_reset_active);
        if (j < 5)
          check("blocks_ready", 16'h0000, blocks_ready);
      end
      check("blocks_ready", 16'h0001, blocks_ready);
      check("serial_tx_en", tx_word[m] & 16'h0007, serial_tx_en);
      host.read_reg(9'h1FF, rd);
      check("status ready", 16'h0001, rd);
      host.read_reg(9'h029, rd);
      check("image_core_config", 16'h085A, rd);
      // Back-to-back samples, each output checked one cycle later
      for (int k = 0; k <= 8; k++)
      begin
        @(posedge ref_clk);
        #1;
        if (k > 0)
        begin
          check("sample_out_valid", 16'h0001, sample_out_valid);
          check("sample_out", exp_sample(prev, px8[m]), sample_out);
        end
        rng = xorshift(rng);
        prev = rng[9:0];
        sample_in = prev;
        sample_valid = (k < 8);
      end
      @(posedge ref_clk);
      #1;
      check("sample_out_valid", 16'h0000, sample_out_valid);
      rng = xorshift(rng);
      mode = rng[14:0];
      host.write_reg(9'h0C0, {mode, 1'b1});
      for (int t = 0; t < 30 && seq_running !== 1'b1; t++)
      begin
        @(posedge ref_clk);
        #1;
      end
      if (seq_running !== 1'b1)
      begin
        $display("MISMATCH seq_running start timed out");
        err_count++;
        print_verdict();
      end
      check("frame_start", 16'h0001, frame_start);
      check("seq_mode", {1'b0, mode}, seq_mode);
      pulses = 1;
      repeat (4 * FRAME - 1)
      begin
        @(posedge ref_clk);
        #1;
        if (frame_start === 1'b1)
          pulses++;
      end
      check("frame_start count", 16'h0004, pulses[15:0]);
      host.read_reg(9'h1FF, rd);
      check("status running", 16'h0003, rd);
      host.write_reg(9'h0C0, {mode, 1'b0});
      settle();
      check("seq_running", 16'h0000, seq_running);
      check("frame_start", 16'h0000, frame_start);
    end
    // Unmapped place stores and reads back
    rng = xorshift(rng);
    host.write_reg(9'h1F0, rng[15:0]);
    host.read_reg(9'h1F0, rd);
    check("unmapped readback", rng[15:0], rd);
    host.write_reg(9'h029, 16'h085B);
    settle();
    check("cfg_error", 16'h0001, cfg_error);
    do_reset();
    check("cfg_error", 16'h0000, cfg_error);
    print_verdict();
  end
endmodule : test_sensor_power_up_upload_sequencer
